// File: hw/mmd_pkg.sv
// Constants and types shared by the memory-map address decoder.
// Assumes a 16-bit core with separate program, data and I/O spaces.
package mmd_pkg;

    localparam int ADDR_W = 16;
    localparam int DATA_W = 16;
    localparam int SYNC_STAGES = 2;

    // Access space driven by the core
    typedef enum logic [1:0] {
        SPACE_PROG,
        SPACE_DATA,
        SPACE_IO
    } mmd_space_t;

    // One target per access; order is the bit index of the select vector
    typedef enum logic [3:0] {
        TGT_FLASH,
        TGT_FLASH_REGS,
        TGT_BOOT,
        TGT_BLK0,
        TGT_BLK1,
        TGT_BLK2,
        TGT_SARAM,
        TGT_PERIPH,
        TGT_CORE_REGS,
        TGT_FMODE_REG,
        TGT_WAIT_REG,
        TGT_EXTERNAL,
        TGT_RESERVED
    } mmd_tgt_t;
    localparam int TGT_N = 13;

    // Program space
    localparam logic [15:0] P_BOOT_LAST  = 16'h00FF;
    localparam logic [15:0] P_PASS_FIRST = 16'h0040;
    localparam logic [15:0] P_PASS_LAST  = 16'h0043;
    localparam logic [15:0] P_SEC1_BASE  = 16'h1000;
    localparam logic [15:0] P_SEC2_BASE  = 16'h4000;
    localparam logic [15:0] P_SEC3_BASE  = 16'h7000;
    localparam logic [15:0] P_FLASH_LAST = 16'h7FFF;
    localparam logic [15:0] P_SARAM_BASE = 16'h8000;
    localparam logic [15:0] P_SARAM_LAST = 16'h87FF;
    localparam logic [15:0] P_BLK0_FIRST = 16'hFE00;

    // Data space
    localparam logic [15:0] D_CORE_LAST  = 16'h005F;
    localparam logic [15:0] D_BLK2_BASE  = 16'h0060;
    localparam logic [15:0] D_BLK2_LAST  = 16'h007F;
    localparam logic [15:0] D_BLK0_FIRST = 16'h0100;
    localparam logic [15:0] D_BLK0_LAST  = 16'h02FF;
    localparam logic [15:0] D_BLK0_UPPER = 16'h0200;
    localparam logic [15:0] D_BLK1_FIRST = 16'h0300;
    localparam logic [15:0] D_BLK1_LAST  = 16'h04FF;
    localparam logic [15:0] D_SARAM_BASE = 16'h0800;
    localparam logic [15:0] D_SARAM_LAST = 16'h0FFF;
    localparam logic [15:0] D_PERI_BASE  = 16'h7000;
    localparam logic [15:0] D_PERI_LAST  = 16'h7FFF;
    localparam logic [15:0] D_EXT_BASE   = 16'h8000;

    // I/O space control registers
    localparam logic [15:0] IO_FMODE_ADDR = 16'hFF0F;
    localparam logic [15:0] IO_WAIT_ADDR  = 16'hFFFF;
    localparam logic [15:0] FMODE_RST     = 16'h0000;
    localparam logic [15:0] WAIT_RST      = 16'h0000;
    localparam int          FMODE_REGS_BIT = 0;

endpackage

// File: hw/mmd_dec_if.sv
// Carrier between the decoder top and its address decode core.
// Assumes both ends sit on the same core clock; all signals combinational.
`timescale 1ns/100ps
interface mmd_dec_if;
    import mmd_pkg::*;

    mmd_space_t  space;
    logic [15:0] addr;
    logic        blk_cfg;
    logic        prog_ram_en;
    logic        data_ram_en;
    logic        ext_prog;
    logic        boot;
    logic        flash_regs;
    mmd_tgt_t    tgt;
    logic [15:0] offset;
    logic [1:0]  sector;
    logic        password;

    modport dec (input  space, addr, blk_cfg, prog_ram_en, data_ram_en,
                        ext_prog, boot, flash_regs,
                 output tgt, offset, sector, password);
    modport user (output space, addr, blk_cfg, prog_ram_en, data_ram_en,
                         ext_prog, boot, flash_regs,
                  input  tgt, offset, sector, password);
endinterface

// File: hw/mmd_space_dec.sv
// Pure address decode: one target, word offset and flash sector per access.
// Assumes the caller registers the results; no state is held here.
`timescale 1ns/100ps
module mmd_space_dec (
    mmd_dec_if.dec d
);
    import mmd_pkg::*;

    wire logic [15:0] a = d.addr;
    wire logic        in_prog = (d.space == SPACE_PROG);
    wire logic        in_data = (d.space == SPACE_DATA);

    wire logic p_boot  = d.boot && (a <= P_BOOT_LAST);
    wire logic p_low   = (a <= P_FLASH_LAST);
    wire logic p_saram = (a >= P_SARAM_BASE) && (a <= P_SARAM_LAST);
    wire logic p_blk0  = (a >= P_BLK0_FIRST);

    // sector and base; sector 1 and 2 are 12K, ends are 4K
    wire logic [1:0]  sec = (a < P_SEC1_BASE) ? 2'h0 :
                            (a < P_SEC2_BASE) ? 2'h1 :
                            (a < P_SEC3_BASE) ? 2'h2 : 2'h3;
    wire logic [15:0] sec_base = (sec == 2'h0) ? 16'h0000 :
                                 (sec == 2'h1) ? P_SEC1_BASE :
                                 (sec == 2'h2) ? P_SEC2_BASE : P_SEC3_BASE;

    // boot overlay wins over flash and external
    mmd_tgt_t p_tgt;
    assign p_tgt = p_boot ? TGT_BOOT :
                   p_low ? (d.ext_prog ? TGT_EXTERNAL :
                            (d.flash_regs ? TGT_FLASH_REGS : TGT_FLASH)) :
                   p_saram ? (d.prog_ram_en ? TGT_SARAM : TGT_EXTERNAL) :
                   (p_blk0 && d.blk_cfg) ? TGT_BLK0 : TGT_EXTERNAL;

    wire logic d_core  = (a <= D_CORE_LAST);
    wire logic d_blk2  = (a >= D_BLK2_BASE) && (a <= D_BLK2_LAST);
    wire logic d_blk0  = (a >= D_BLK0_FIRST) && (a <= D_BLK0_LAST);
    wire logic d_blk1  = (a >= D_BLK1_FIRST) && (a <= D_BLK1_LAST);
    wire logic d_saram = (a >= D_SARAM_BASE) && (a <= D_SARAM_LAST);
    wire logic d_peri  = (a >= D_PERI_BASE) && (a <= D_PERI_LAST);
    wire logic d_ext   = (a >= D_EXT_BASE);

    mmd_tgt_t d_tgt;
    assign d_tgt = d_core ? TGT_CORE_REGS :
                   d_blk2 ? TGT_BLK2 :
                   d_blk0 ? (d.blk_cfg ? TGT_RESERVED : TGT_BLK0) :
                   d_blk1 ? TGT_BLK1 :
                   d_saram ? (d.data_ram_en ? TGT_SARAM : TGT_RESERVED) :
                   d_peri ? TGT_PERIPH :
                   d_ext ? TGT_EXTERNAL : TGT_RESERVED;

    // two on-chip registers, rest off chip
    mmd_tgt_t i_tgt;
    assign i_tgt = (a == IO_FMODE_ADDR) ? TGT_FMODE_REG :
                   (a == IO_WAIT_ADDR) ? TGT_WAIT_REG : TGT_EXTERNAL;

    assign d.tgt = in_prog ? p_tgt : (in_data ? d_tgt : i_tgt);

    // Aliased blocks fold to the low byte so both windows hit one word
    assign d.offset =
        (d.tgt == TGT_BLK0 || d.tgt == TGT_BLK1 || d.tgt == TGT_BOOT) ?
            {8'h00, a[7:0]} :
        (d.tgt == TGT_BLK2) ? {11'h000, a[4:0]} :
        (d.tgt == TGT_SARAM) ? {5'h00, a[10:0]} :
        (d.tgt == TGT_PERIPH) ? {4'h0, a[11:0]} :
        (d.tgt == TGT_FLASH || d.tgt == TGT_FLASH_REGS) ? a - sec_base :
        (d.tgt == TGT_FMODE_REG || d.tgt == TGT_WAIT_REG ||
         d.tgt == TGT_RESERVED) ? 16'h0000 : a;

    assign d.sector   = sec;
    assign d.password = (d.tgt == TGT_FLASH) &&
                        (a >= P_PASS_FIRST) && (a <= P_PASS_LAST);
endmodule

// File: hw/mmd_top.sv
// Memory-map address decoder: steers each core access to one target
// and holds the flash mode and wait-state control registers.
// Assumes the core presents one access per valid cycle on i_mclk.
// Operation
// - Program FE00/FF00 pages both hit block zero when config set, external when clear
// - Data 0100/0200 pages alias block zero
// - Data 0300/0400 pages alias block one
// - Boot ROM overlays program 0000-00FF
// - Program 0040-0043 flagged as password words
// - Mode select picks flash or external
// - Flash decodes as four sectors
// - Data low: core registers, then block two
// - Data 0100/0200 pages reserved when config set
// - Data single-access RAM gated by enable
// - Program single-access RAM gated by enable
// - Data 7000-7FFF selects peripheral registers
// - I/O FF0F selects flash mode register
// - I/O FFFF selects wait-state register
`timescale 1ns/100ps
module mmd_top (
    // Clock and reset
    input  wire logic                     i_mclk,
    input  wire logic                     i_srst,
    // Core access
    input  wire logic                     i_acc_valid,
    input  wire mmd_pkg::mmd_space_t      i_space,
    input  wire logic [15:0]              i_addr,
    input  wire logic                     i_wr,
    input  wire logic [15:0]              i_wdata,
    // Configuration
    input  wire logic                     i_ram_block_config_bit,
    input  wire logic                     i_program_saram_enable,
    input  wire logic                     i_data_saram_enable,
    input  wire logic                     i_microprocessor_mode_select,
    input  wire logic                     i_boot_rom_enable,
    // Decode result
    output logic                          o_valid,
    output logic [mmd_pkg::TGT_N-1:0]     o_sel,
    output mmd_pkg::mmd_tgt_t             o_tgt,
    output logic [15:0]                   o_offset,
    output logic [1:0]                    o_flash_sector,
    output logic                          o_password,
    output logic                          o_illegal,
    // Control registers
    output logic [15:0]                   o_rdata,
    output logic [15:0]                   o_flash_array_mode_control,
    output logic [15:0]                   o_bus_wait_state_control
);
    import mmd_pkg::*;

    logic        mode_meta_q;
    logic        mode_q;
    logic [15:0] fmode_q;
    logic [15:0] wait_q;
    mmd_dec_if dec ();

    // mode select is a pin: two flops first
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            mode_meta_q <= 1'b0;
            mode_q      <= 1'b0;
        end else begin
            mode_meta_q <= i_microprocessor_mode_select;
            mode_q      <= mode_meta_q;
        end
    end

    // Decoder inputs
    assign dec.space       = i_space;
    assign dec.addr        = i_addr;
    assign dec.blk_cfg     = i_ram_block_config_bit;
    assign dec.prog_ram_en = i_program_saram_enable;
    assign dec.data_ram_en = i_data_saram_enable;
    assign dec.ext_prog    = mode_q;
    assign dec.boot        = i_boot_rom_enable;
    assign dec.flash_regs  = fmode_q[FMODE_REGS_BIT];

    mmd_space_dec u_dec (
        .d (dec)
    );

    // Register writes ride on the I/O decode itself
    wire logic acc_fmode = i_acc_valid && (dec.tgt == TGT_FMODE_REG);
    wire logic acc_wait  = i_acc_valid && (dec.tgt == TGT_WAIT_REG);
    wire logic [15:0] rdata_d = (acc_fmode && !i_wr) ? fmode_q :
                                (acc_wait && !i_wr) ? wait_q : 16'h0000;

    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            fmode_q <= FMODE_RST;
            wait_q  <= WAIT_RST;
        end else begin
            if (acc_fmode && i_wr) fmode_q <= i_wdata;
            if (acc_wait && i_wr)  wait_q  <= i_wdata;
        end
    end

    logic [TGT_N-1:0] sel_d;
    genvar gi;
    generate
        for (gi = 0; gi < TGT_N; gi++) begin : g_sel
            assign sel_d[gi] = i_acc_valid && (dec.tgt == gi);
        end
    endgenerate

    // Results are registered so consumers see clean flop outputs
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_valid        <= 1'b0;
            o_sel          <= '0;
            o_tgt          <= TGT_RESERVED;
            o_offset       <= 16'h0000;
            o_flash_sector <= 2'h0;
            o_password     <= 1'b0;
            o_illegal      <= 1'b0;
            o_rdata        <= 16'h0000;
        end else begin
            o_valid        <= i_acc_valid;
            o_sel          <= sel_d;
            o_tgt          <= dec.tgt;
            o_offset       <= dec.offset;
            o_flash_sector <= dec.sector;
            o_password     <= i_acc_valid && dec.password;
            o_illegal      <= i_acc_valid && (dec.tgt == TGT_RESERVED);
            o_rdata        <= rdata_d;
        end
    end

    // Register contents are visible continuously
    assign o_flash_array_mode_control = fmode_q;
    assign o_bus_wait_state_control   = wait_q;

    // Helpers for the checks below
    wire logic acc_p = i_acc_valid && (i_space == SPACE_PROG);
    wire logic acc_d = i_acc_valid && (i_space == SPACE_DATA);
    wire logic acc_i = i_acc_valid && (i_space == SPACE_IO);

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_srst);

    a_blk0_prog_alias: assert property (
        acc_p && i_ram_block_config_bit && i_addr >= P_BLK0_FIRST
        |=> o_sel[TGT_BLK0] && o_offset == {8'h00, $past(i_addr[7:0])})
        else $error("program block zero alias wrong");

    a_blk0_data_alias: assert property (
        acc_d && !i_ram_block_config_bit && i_addr >= D_BLK0_FIRST &&
        i_addr <= D_BLK0_LAST
        |=> o_tgt == TGT_BLK0 && o_offset == {8'h00, $past(i_addr[7:0])})
        else $error("data block zero alias wrong");

    a_blk1_alias_pair: assert property (
        acc_d && i_addr >= D_BLK1_FIRST && i_addr <= D_BLK1_LAST
        |=> o_sel[TGT_BLK1] && o_offset == {8'h00, $past(i_addr[7:0])})
        else $error("block one alias wrong");

    a_boot_overlay: assert property (
        acc_p && i_boot_rom_enable && i_addr <= P_BOOT_LAST
        |=> o_tgt == TGT_BOOT && !o_sel[TGT_FLASH])
        else $error("boot overlay missing");

    a_password_flag: assert property (
        o_password |-> o_tgt == TGT_FLASH && o_offset >= P_PASS_FIRST &&
        o_offset <= P_PASS_LAST)
        else $error("password flag on wrong word");

    a_mode_select: assert property (
        acc_p && !i_boot_rom_enable && i_addr <= P_FLASH_LAST
        |=> (o_tgt == TGT_EXTERNAL) == $past(mode_q))
        else $error("mode select routing wrong");

    a_flash_sector: assert property (
        acc_p && !i_boot_rom_enable && !mode_q && fmode_q == 16'h0000 &&
        i_addr >= P_SEC1_BASE && i_addr < P_SEC2_BASE
        |=> o_flash_sector == 2'h1 &&
            o_offset == $past(i_addr) - P_SEC1_BASE)
        else $error("flash sector decode wrong");

    a_core_blk2_split: assert property (
        acc_d && i_addr <= D_BLK2_LAST
        |=> o_tgt == ($past(i_addr) <= D_CORE_LAST ? TGT_CORE_REGS
                                                   : TGT_BLK2))
        else $error("low data split wrong");

    a_blk0_reserved: assert property (
        acc_d && i_ram_block_config_bit && i_addr >= D_BLK0_UPPER &&
        i_addr <= D_BLK0_LAST |=> o_illegal)
        else $error("block zero page not reserved");

    a_data_saram: assert property (
        acc_d && i_addr >= D_SARAM_BASE && i_addr <= D_SARAM_LAST
        |=> o_sel[TGT_SARAM] == $past(i_data_saram_enable) &&
            o_illegal == !$past(i_data_saram_enable))
        else $error("data SARAM gating wrong");

    a_prog_saram: assert property (
        acc_p && i_addr >= P_SARAM_BASE && i_addr <= P_SARAM_LAST
        |=> o_tgt == ($past(i_program_saram_enable) ? TGT_SARAM
                                                    : TGT_EXTERNAL))
        else $error("program SARAM gating wrong");

    a_periph_space: assert property (
        acc_d && i_addr >= D_PERI_BASE && i_addr <= D_PERI_LAST
        |=> o_sel[TGT_PERIPH])
        else $error("peripheral space missed");

    a_fmode_write: assert property (
        acc_i && i_wr && i_addr == IO_FMODE_ADDR
        |=> o_sel[TGT_FMODE_REG] ##1
            o_flash_array_mode_control == $past(i_wdata, 2))
        else $error("flash mode register not written");

    a_wait_write: assert property (
        acc_i && i_wr && i_addr == IO_WAIT_ADDR
        |=> o_bus_wait_state_control == $past(i_wdata) &&
            !o_sel[TGT_EXTERNAL])
        else $error("wait-state register not written");

    a_one_select: assert property (
        o_valid |-> $onehot(o_sel) && o_illegal == o_sel[TGT_RESERVED])
        else $error("select not one-hot");

    c_blk0_prog: cover property (acc_p && i_ram_block_config_bit &&
                                 i_addr >= P_BLK0_FIRST);
    c_reg_rw: cover property (acc_i && i_wr && i_addr == IO_WAIT_ADDR
                              ##1 acc_i && !i_wr && i_addr == IO_WAIT_ADDR);
    c_illegal: cover property (o_illegal);
    c_password: cover property (o_password);
endmodule

// File: tb/mmd_core_model.sv
// Core-side model: presents program, data and I/O accesses to the decoder.
// Assumes callers enter its tasks just after a falling edge of i_mclk.
`timescale 1ns/100ps
module mmd_core_model (
    // Clock
    input  wire logic           i_mclk,
    // Access to the decoder
    output logic                o_acc_valid,
    output mmd_pkg::mmd_space_t o_space,
    output logic [15:0]         o_addr,
    output logic                o_wr,
    output logic [15:0]         o_wdata
);
    import mmd_pkg::*;

    // user code above vectors and passwords
    localparam logic [15:0] CODE_START = 16'h0044;

    // Quiet bus at time zero
    initial begin
        o_acc_valid = 1'b0;
        o_space     = SPACE_DATA;
        o_addr      = 16'h0000;
        o_wr        = 1'b0;
        o_wdata     = 16'h0000;
    end

    // One access held for a full cycle; valid stays up for back-to-back use
    task automatic access(input mmd_space_t sp, input logic [15:0] a,
                          input logic w, input logic [15:0] wd);
        o_acc_valid = 1'b1;
        o_space     = sp;
        o_addr      = a;
        o_wr        = w;
        o_wdata     = wd;
        @(negedge i_mclk);
    endtask

    // Release: address and data invert so stale values never match
    task automatic idle();
        o_acc_valid = 1'b0;
        o_wr        = 1'b0;
        o_addr      = ~o_addr;
        o_wdata     = ~o_wdata;
        @(negedge i_mclk);
    endtask
endmodule

// File: tb/memory_map_address_decoder_tb.sv
// Self-checking bench for the memory-map decoder top.
// Assumes mmd_top answers each access exactly one cycle later.
`timescale 1ns/100ps
module memory_map_address_decoder_tb;
    import mmd_pkg::*;

    logic                i_mclk;
    logic                i_srst;
    logic                blk_cfg;
    logic                prog_ram_en;
    logic                data_ram_en;
    logic                mode_pin;
    logic                boot;
    logic                acc_valid;
    mmd_space_t          space;
    logic [15:0]         addr;
    logic                wr;
    logic [15:0]         wdata;
    logic                o_valid;
    logic [TGT_N-1:0]    o_sel;
    mmd_tgt_t            o_tgt;
    logic [15:0]         o_offset;
    logic [1:0]          o_flash_sector;
    logic                o_password;
    logic                o_illegal;
    logic [15:0]         o_rdata;
    logic [15:0]         o_fmode;
    logic [15:0]         o_wait;
    int                  error_cnt;
    int                  comparisons;

    // 40 MHz core clock
    initial i_mclk = 1'b0;
    always #12.5 i_mclk = ~i_mclk;

    mmd_core_model u_core (
        .i_mclk(i_mclk), .o_acc_valid(acc_valid), .o_space(space),
        .o_addr(addr), .o_wr(wr), .o_wdata(wdata)
    );

    mmd_top u_dut (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_acc_valid(acc_valid),
        .i_space(space), .i_addr(addr), .i_wr(wr), .i_wdata(wdata),
        .i_ram_block_config_bit(blk_cfg),
        .i_program_saram_enable(prog_ram_en),
        .i_data_saram_enable(data_ram_en),
        .i_microprocessor_mode_select(mode_pin),
        .i_boot_rom_enable(boot), .o_valid(o_valid), .o_sel(o_sel),
        .o_tgt(o_tgt), .o_offset(o_offset),
        .o_flash_sector(o_flash_sector), .o_password(o_password),
        .o_illegal(o_illegal), .o_rdata(o_rdata),
        .o_flash_array_mode_control(o_fmode),
        .o_bus_wait_state_control(o_wait)
    );

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            error_cnt++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen,
                     exp);
        end
    endtask

    // One read access, then target, one-hot select and offset
    task automatic dec(input mmd_space_t sp, input logic [15:0] a,
                       input mmd_tgt_t t, input logic [15:0] off);
        u_core.access(sp, a, 1'b0, 16'h0000);
        check({15'h0000, o_valid}, 16'h0001);
        check({3'h0, o_sel}, 16'h0001 << t);
        check({12'h000, o_tgt}, {12'h000, t});
        check(o_offset, off);
        check({15'h0000, o_illegal}, {15'h0000, t == TGT_RESERVED});
    endtask

    // Program flash access with sector and password flag
    task automatic fl(input logic [15:0] a, input logic [15:0] off,
                      input logic [1:0] sec, input logic pw);
        dec(SPACE_PROG, a, TGT_FLASH, off);
        check({14'h0000, o_flash_sector}, {14'h0000, sec});
        check({15'h0000, o_password}, {15'h0000, pw});
    endtask

    // Write then read back one I/O location
    task automatic io_rw(input logic [15:0] a, input mmd_tgt_t t,
                         input logic [15:0] d);
        u_core.access(SPACE_IO, a, 1'b1, d);
        check({12'h000, o_tgt}, {12'h000, t});
        u_core.access(SPACE_IO, a, 1'b0, 16'h0000);
        check(o_rdata, (t == TGT_EXTERNAL) ? 16'h0000 : d);
    endtask

    // Mode select crosses two flops, so settle three cycles
    task automatic set_cfg(input logic c, input logic p, input logic d,
                           input logic m, input logic b);
        blk_cfg     = c;
        prog_ram_en = p;
        data_ram_en = d;
        mode_pin    = m;
        boot        = b;
        repeat (3) u_core.idle();
    endtask

    // Hang guard well beyond the planned run
    initial begin
        #125000;
        error_cnt++;
        report_and_stop();
    end

    initial begin
        i_srst = 1'b1;
        {blk_cfg, prog_ram_en, data_ram_en, mode_pin, boot} = 5'h00;
        error_cnt = 0;
        comparisons = 0;
        repeat (16) @(negedge i_mclk);
        check({12'h000, o_tgt}, {12'h000, TGT_RESERVED});
        check({3'h0, o_sel}, 16'h0000);
        check(o_fmode, FMODE_RST);
        check(o_wait, WAIT_RST);
        i_srst = 1'b0;
        @(negedge i_mclk);
        $display("test reset done");

        io_rw(16'hFF0F, TGT_FMODE_REG, 16'h1234);
        io_rw(16'hFFFF, TGT_WAIT_REG, 16'hABCD);
        io_rw(16'h1234, TGT_EXTERNAL, 16'hFFFF);
        io_rw(16'hFF0E, TGT_EXTERNAL, 16'h5555);
        check(o_fmode, 16'h1234);
        check(o_wait, 16'hABCD);
        u_core.idle();
        check({3'h0, o_sel}, 16'h0000);
        $display("test io_regs done");

        fl(16'h0000, 16'h0000, 2'd0, 1'b0);
        fl(16'h003F, 16'h003F, 2'd0, 1'b0);
        fl(16'h0040, 16'h0040, 2'd0, 1'b1);
        fl(16'h0043, 16'h0043, 2'd0, 1'b1);
        fl(u_core.CODE_START, 16'h0044, 2'd0, 1'b0);
        fl(16'h0FFF, 16'h0FFF, 2'd0, 1'b0);
        fl(16'h1000, 16'h0000, 2'd1, 1'b0);
        fl(16'h3FFF, 16'h2FFF, 2'd1, 1'b0);
        fl(16'h4000, 16'h0000, 2'd2, 1'b0);
        fl(16'h6FFF, 16'h2FFF, 2'd2, 1'b0);
        fl(16'h7000, 16'h0000, 2'd3, 1'b0);
        fl(16'h7FFF, 16'h0FFF, 2'd3, 1'b0);
        dec(SPACE_PROG, 16'h8000, TGT_EXTERNAL, 16'h8000);
        dec(SPACE_PROG, 16'hFF05, TGT_EXTERNAL, 16'hFF05);
        dec(SPACE_DATA, 16'h005F, TGT_CORE_REGS, 16'h005F);
        dec(SPACE_DATA, 16'h0060, TGT_BLK2, 16'h0000);
        dec(SPACE_DATA, 16'h007F, TGT_BLK2, 16'h001F);
        dec(SPACE_DATA, 16'h0080, TGT_RESERVED, 16'h0000);
        dec(SPACE_DATA, 16'h0105, TGT_BLK0, 16'h0005);
        dec(SPACE_DATA, 16'h0205, TGT_BLK0, 16'h0005);
        dec(SPACE_DATA, 16'h0312, TGT_BLK1, 16'h0012);
        dec(SPACE_DATA, 16'h0412, TGT_BLK1, 16'h0012);
        dec(SPACE_DATA, 16'h0800, TGT_RESERVED, 16'h0000);
        dec(SPACE_DATA, 16'h6FFF, TGT_RESERVED, 16'h0000);
        dec(SPACE_DATA, 16'h7123, TGT_PERIPH, 16'h0123);
        dec(SPACE_DATA, 16'h7FFF, TGT_PERIPH, 16'h0FFF);
        dec(SPACE_DATA, 16'h8000, TGT_EXTERNAL, 16'h8000);
        $display("test map_cnf0 done");

        set_cfg(1'b1, 1'b1, 1'b1, 1'b0, 1'b1);
        dec(SPACE_PROG, 16'h0010, TGT_BOOT, 16'h0010);
        dec(SPACE_PROG, 16'h00FF, TGT_BOOT, 16'h00FF);
        fl(16'h0100, 16'h0100, 2'd0, 1'b0);
        dec(SPACE_PROG, 16'hFE07, TGT_BLK0, 16'h0007);
        dec(SPACE_PROG, 16'hFF07, TGT_BLK0, 16'h0007);
        dec(SPACE_DATA, 16'h0205, TGT_RESERVED, 16'h0000);
        dec(SPACE_DATA, 16'h0412, TGT_BLK1, 16'h0012);
        dec(SPACE_DATA, 16'h0800, TGT_SARAM, 16'h0000);
        dec(SPACE_DATA, 16'h0FFF, TGT_SARAM, 16'h07FF);
        dec(SPACE_PROG, 16'h8000, TGT_SARAM, 16'h0000);
        dec(SPACE_PROG, 16'h87FF, TGT_SARAM, 16'h07FF);
        dec(SPACE_PROG, 16'h8800, TGT_EXTERNAL, 16'h8800);
        $display("test map_cnf1 done");

        set_cfg(1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
        dec(SPACE_PROG, 16'h0000, TGT_EXTERNAL, 16'h0000);
        dec(SPACE_PROG, 16'h0041, TGT_EXTERNAL, 16'h0041);
        check({15'h0000, o_password}, 16'h0000);
        dec(SPACE_PROG, 16'h7FFF, TGT_EXTERNAL, 16'h7FFF);
        set_cfg(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
        fl(16'h7FFF, 16'h0FFF, 2'd3, 1'b0);
        // Mode register bit 0 turns flash into its register window
        io_rw(16'hFF0F, TGT_FMODE_REG, 16'h0001);
        dec(SPACE_PROG, 16'h0041, TGT_FLASH_REGS, 16'h0041);
        check({15'h0000, o_password}, 16'h0000);
        check({14'h0000, o_flash_sector}, 16'h0000);
        io_rw(16'hFF0F, TGT_FMODE_REG, 16'h0000);
        fl(16'h0041, 16'h0041, 2'd0, 1'b1);
        u_core.idle();
        $display("test mode_select done");
        report_and_stop();
    end
endmodule
